// ===== pors_defines.svh
// Purpose: Constants for the power-on reset sequencer.
// Assumes: Reference clock of 20 MHz.
// Notes:   Timing counts derive from the times in their own units.
// Contract
// RL1: While power-on sense is low the chip stays in system reset with all outputs high impedance or low.
// RL2: The master PLL leaves reset on the rising edge of power-on sense while the rest stays in reset.
// RL3: After that edge all logic other than the master PLL stays in reset for a further 100 ms.
// RL4: When the 100 ms wait ends the processor resets are released and the processor boots.
// RL5: Power-up initialization selects normal power mode with full-rate processor clocks and processor resets released.
// RL6: Clocks outside the processor domain come up disabled with resets asserted until software enables them.
// RL7: The same clock and reset defaults are applied on every system reset without a power cycle, watchdog included.
// RL8: The processor boots from flash, then enables the other clocks, and software alone picks low-power mode.
// RL9: The external monitor keeps power-on sense low until every supply is at its minimum level.
// RL10: The supply warning arrives at least 500 us before the supplies leave specification.
// RL11: On a supply warning the micromirror array is parked before power is lost. The code acts on the warning only in the run state.
// RL12: Power-on sense is synchronised and the 100 ms hold is timed by a counter held in reset while sense is low.
`ifndef PORS_DEFINES_SVH
`define PORS_DEFINES_SVH
`define PORS_CLK_HZ       20000000
`define PORS_HOLD_MS      100
`define PORS_HOLD_CYCLES  ((`PORS_CLK_HZ / 1000) * `PORS_HOLD_MS)
`define PORS_CNT_W        22
`define PORS_DOMAIN_W     8
`define PORS_DOMAINS_OFF  8'h00
`define PORS_MODE_NORMAL  1'b0
`endif

// ===== pors_pkg.sv
// Purpose: Types for the power-on reset sequencer.
// Assumes: Nothing beyond the defines header.
// Notes:   The control struct groups the PLL reset, processor reset, I/O enable and power-mode outputs.
`include "pors_defines.svh"
package pors_pkg;
	typedef enum logic [2:0] {PORS_OFF, PORS_PLL_WAIT, PORS_RUN, PORS_PARK, PORS_PARKED} pors_state_t;
	typedef struct packed {
		logic masterPllReset;
		logic cpuReset;
		logic ioEnable;
		logic lowPowerMode;
	} pors_ctrl_t;
endpackage : pors_pkg

// ===== pors_power_on_reset_sequencer.sv
// Purpose: Sequences system resets from power-on sense and parks the mirrors on a supply warning seen in the run state.
// Assumes: Sense and warning are asynchronous pins; software controls arrive on ref_clk.
// Notes:   Peripheral clocks stay off until the processor enables them.
`timescale 1ns/1ps
module pors_power_on_reset_sequencer
	import pors_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = `PORS_HOLD_CYCLES,
	parameter int unsigned DOMAINS     = `PORS_DOMAIN_W
) (
	input  wire logic                 ref_clk,
	input  wire logic                 reset,
	input  wire logic                 powerOnSense,
	input  wire logic                 supplyWarning,
	input  wire logic                 watchdogReset,
	input  wire logic [DOMAINS-1:0]   swClockEnable,
	input  wire logic [DOMAINS-1:0]   swResetRelease,
	input  wire logic                 swLowPowerReq,
	input  wire logic                 mirrorParkDone,
	output pors_ctrl_t                ctrl,
	output logic      [DOMAINS-1:0]   domainClockEnable,
	output logic      [DOMAINS-1:0]   domainReset,
	output logic                      mirrorParkReq,
	output logic                      systemReady
);
	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic senseMeta;
	logic sense;
	logic senseDly;
	logic warnMeta;
	logic warn;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			senseMeta <= 1'b0;
			sense     <= 1'b0;
			senseDly  <= 1'b0;
			warnMeta  <= 1'b0;
			warn      <= 1'b0;
		end else begin
			senseMeta <= powerOnSense; // [RL12]
			sense     <= senseMeta;
			senseDly  <= sense;
			warnMeta  <= supplyWarning;
			warn      <= warnMeta;
		end
	end
	logic senseRise;
	assign senseRise = sense & ~senseDly;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	pors_state_t state;
	logic [`PORS_CNT_W-1:0] holdCnt;
	logic holdDone;
	assign holdDone = (holdCnt >= `PORS_CNT_W'(HOLD_CYCLES - 1));

	// Counter only runs in the PLL wait and is cleared whenever sense drops.
	always_ff @(posedge ref_clk) begin
		if (reset || !sense || state != PORS_PLL_WAIT) begin
			holdCnt <= '0; // [RL12]
		end else if (!holdDone) begin
			holdCnt <= holdCnt + `PORS_CNT_W'(1); // [RL3]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || !sense) begin
			state <= PORS_OFF; // [RL1]
		end else begin
			unique case (state)
				PORS_OFF: begin
					if (senseRise) begin
						state <= PORS_PLL_WAIT; // [RL2]
					end
				end
				PORS_PLL_WAIT: begin
					if (holdDone) begin
						state <= PORS_RUN; // [RL4]
					end
				end
				PORS_RUN: begin
					if (warn) begin
						state <= PORS_PARK; // [RL11]
					end else if (watchdogReset) begin
						state <= PORS_PLL_WAIT; // [RL7]
					end
				end
				PORS_PARK: begin
					if (mirrorParkDone) begin
						state <= PORS_PARKED;
					end
				end
				PORS_PARKED: begin
					state <= PORS_PARKED;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	logic running;
	assign running = (state == PORS_RUN);

	// A watchdog reset reapplies all defaults, including peripheral domains.
	always_ff @(posedge ref_clk) begin
		if (reset || !running || watchdogReset) begin
			domainClockEnable <= `PORS_DOMAINS_OFF; // [RL6] [RL7]
			domainReset       <= ~`PORS_DOMAINS_OFF;
		end else begin
			domainClockEnable <= swClockEnable; // [RL8]
			domainReset       <= ~swResetRelease;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset || !running || watchdogReset) begin
			ctrl.lowPowerMode <= `PORS_MODE_NORMAL; // [RL5]
		end else begin
			ctrl.lowPowerMode <= swLowPowerReq; // [RL8]
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ctrl.masterPllReset <= 1'b1;
			ctrl.cpuReset       <= 1'b1;
			ctrl.ioEnable       <= 1'b0;
			mirrorParkReq       <= 1'b0;
			systemReady         <= 1'b0;
		end else begin
			ctrl.masterPllReset <= (state == PORS_OFF) && !senseRise; // [RL2]
			ctrl.cpuReset       <= !(running || state == PORS_PARK) || (running && watchdogReset); // [RL4] [RL5]
			ctrl.ioEnable       <= (state != PORS_OFF) && (state != PORS_PLL_WAIT); // [RL1]
			// The request stays up once parked so the mirrors are not released before power goes.
			mirrorParkReq       <= (state == PORS_PARK) || (state == PORS_PARKED) || (running && warn); // [RL11]
			systemReady         <= running;
		end
	end
endmodule : pors_power_on_reset_sequencer

// ===== pors_seq_props.sv
// Purpose: Port assertions for the sequencer.
// Assumes: HOLD_CYCLES equals the bound instance value.
// Notes: Bound after the module.
`timescale 1ns/1ps
module pors_seq_props
	import pors_pkg::*;
#(parameter int unsigned HOLD_CYCLES = 20) (
	input wire logic       ref_clk,
	input wire logic       reset,
	input wire logic       powerOnSense,
	input wire logic       supplyWarning,
	input wire logic       watchdogReset,
	input wire logic       swLowPowerReq,
	input pors_ctrl_t      ctrl,
	input wire logic [7:0] domainClockEnable,
	input wire logic [7:0] domainReset,
	input wire logic       mirrorParkReq,
	input wire logic       systemReady
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	property p_off; !powerOnSense [*5] |-> ctrl.masterPllReset && ctrl.cpuReset && !ctrl.ioEnable; endproperty
	a_off: assert property (p_off) else $error("not in reset");
	property p_pll; $rose(powerOnSense) |-> ctrl.cpuReset throughout ##[2:5] !ctrl.masterPllReset; endproperty
	a_pll: assert property (p_pll) else $error("pll release");
	property p_hold; $fell(ctrl.cpuReset) |-> $past(ctrl.masterPllReset, HOLD_CYCLES) == 1'b0; endproperty
	a_hold: assert property (p_hold) else $error("hold short");
	property p_run; $fell(ctrl.cpuReset) |-> systemReady && ctrl.ioEnable && !ctrl.lowPowerMode; endproperty
	a_run: assert property (p_run) else $error("run state");
	property p_dom; ctrl.cpuReset && $past(ctrl.cpuReset) |-> domainClockEnable == 8'h00 && &domainReset; endproperty
	a_dom: assert property (p_dom) else $error("domain on");
	property p_wd; systemReady && watchdogReset |-> ##[1:2] ctrl.cpuReset && !ctrl.masterPllReset; endproperty
	a_wd: assert property (p_wd) else $error("watchdog");
	property p_lp; systemReady && swLowPowerReq |=> ctrl.lowPowerMode; endproperty
	a_lp: assert property (p_lp) else $error("low power");
	property p_park; $rose(supplyWarning) && systemReady |-> ##[2:4] mirrorParkReq; endproperty
	a_park: assert property (p_park) else $error("no park");
endmodule : pors_seq_props
bind pors_power_on_reset_sequencer pors_seq_props #(.HOLD_CYCLES(HOLD_CYCLES)) u_props (.*);

// ===== pors_supply_model.sv
// Purpose: Supply monitor model.
// Assumes: Bench sets the supply state.
// Notes: Sense falls 10000 cycles after warning.
`timescale 1ns/1ps
module pors_supply_model (
	input wire logic ref_clk,
	input wire logic suppliesUp,
	input wire logic failAhead,
	output logic     powerOnSense,
	output logic     supplyWarning
);
	int unsigned warnAge = 0;
	initial {powerOnSense, supplyWarning} = 2'b00;
	// The warning leads the loss by 500 us so the mirrors have time to park.
	always @(negedge ref_clk) begin
		supplyWarning <= failAhead;
		warnAge <= failAhead ? warnAge + 1 : 0;
		powerOnSense <= suppliesUp && warnAge < 10000;
	end
endmodule : pors_supply_model

// ===== tb_power_on_reset_sequencer.sv
// Purpose: Self-checking bench for the sequencer.
// Assumes: Short hold count keeps the run brief.
// Notes: Inputs change on falling edges.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; $display("wrong value %0t %h %h", $time, a, e); end end
module tb_power_on_reset_sequencer;
	localparam int unsigned HOLD_CYCLES = 20;
	logic ref_clk = 0, reset = 1, watchdogReset = 0, swLowPowerReq = 0, mirrorParkDone = 0;
	logic suppliesUp = 0, failAhead = 0, powerOnSense, supplyWarning, mirrorParkReq, systemReady;
	logic [7:0] swClockEnable = 8'h00, swResetRelease = 8'h00, domainClockEnable, domainReset;
	pors_pkg::pors_ctrl_t ctrl;
	int n_mismatch = 0, n_tests = 0, cycles = 0;
	logic [7:0] rows [3][4] = '{'{8'h01, 8'h01, 8'h00, 8'hfe}, '{8'hff, 8'h00, 8'h01, 8'hff},
		'{8'ha5, 8'hf0, 8'h00, 8'h0f}};
	pors_supply_model partner (.*);
	pors_power_on_reset_sequencer #(.HOLD_CYCLES(HOLD_CYCLES)) dut (.*);
	initial forever #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (++cycles == 12000) begin n_mismatch++; results(); end
	always @(negedge ref_clk) mirrorParkDone <= mirrorParkReq;
	task automatic results;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : results
	task automatic tick(int n);
		repeat (n) @(negedge ref_clk);
	endtask : tick
	initial begin
		tick(6);
		reset = 0;
		tick(2);
		`CHK({ctrl, domainClockEnable, domainReset, mirrorParkReq, systemReady}, {4'hc, 8'h00, 8'hff, 2'h0})
		suppliesUp = 1;
		tick(7);
		`CHK(ctrl, 4'h4)
		tick(HOLD_CYCLES - 6);
		`CHK(ctrl.cpuReset, 1'b1)
		tick(12);
		`CHK({ctrl, systemReady}, 5'h05)
		foreach (rows[i]) begin
			{swClockEnable, swResetRelease, swLowPowerReq} = {rows[i][0], rows[i][1], rows[i][2][0]};
			tick(3);
			`CHK({domainClockEnable, domainReset, ctrl.lowPowerMode}, {rows[i][0], rows[i][3], rows[i][2][0]})
		end
		// A watchdog must not restart the PLL, only rerun the hold.
		watchdogReset = 1;
		tick(1);
		watchdogReset = 0;
		tick(2);
		`CHK({ctrl[3:1], domainClockEnable, domainReset}, {3'b010, 8'h00, 8'hff})
		tick(HOLD_CYCLES + 8);
		`CHK(systemReady, 1'b1)
		failAhead = 1;
		tick(6);
		`CHK(mirrorParkReq, 1'b1)
		tick(10010);
		`CHK({ctrl, mirrorParkReq, systemReady}, 6'h30)
		results();
	end
endmodule : tb_power_on_reset_sequencer
